// ==== inc/flash_fe_pkg.sv ====
// opcodes, sizes, state codes and decode helpers of the flash command front end
package flash_fe_pkg;

	localparam logic [7:0] OP_RD_STAT1 = 8'h05;
	localparam logic [7:0] OP_RD_STAT2 = 8'h35;
	localparam logic [7:0] OP_RD_SR3A  = 8'h15;
	localparam logic [7:0] OP_RD_SR3B  = 8'h33;
	localparam logic [7:0] OP_WEL_SET  = 8'h06;
	localparam logic [7:0] OP_VWEL_SET = 8'h50;
	localparam logic [7:0] OP_WEL_CLR  = 8'h04;
	localparam logic [7:0] OP_SR_WR1   = 8'h01;
	localparam logic [7:0] OP_SR_WR2   = 8'h31;
	localparam logic [7:0] OP_SR_WR3   = 8'h11;
	localparam logic [7:0] OP_WRAP     = 8'h77;
	localparam logic [7:0] OP_G_LOCK   = 8'h7E;
	localparam logic [7:0] OP_G_UNLOCK = 8'h98;
	localparam logic [7:0] OP_PAGE_WR  = 8'h02;
	localparam logic [7:0] OP_QPAGE_WR = 8'h32;
	localparam logic [7:0] OP_ER_4K    = 8'h20;
	localparam logic [7:0] OP_ER_32K   = 8'h52;
	localparam logic [7:0] OP_ER_64K   = 8'hD8;
	localparam logic [7:0] OP_ER_CHIPA = 8'hC7;
	localparam logic [7:0] OP_ER_CHIPB = 8'h60;
	localparam logic [7:0] OP_SUSPEND  = 8'h75;
	localparam logic [7:0] OP_RESUME   = 8'h7A;
	localparam logic [7:0] OP_QUAD_ON  = 8'h38;
	localparam logic [7:0] OP_RST_EN   = 8'h66;
	localparam logic [7:0] OP_RST      = 8'h99;
	localparam logic [7:0] OP_SLEEP    = 8'hB9;
	localparam logic [7:0] OP_WAKE     = 8'hAB;

	localparam int ADDR_BYTES  = 3;
	localparam int SR_WR_MAX   = 3;
	localparam int WRAP_BYTE   = 4;
	localparam int PAGE_BYTES  = 256;
	localparam int FIFO_DEPTH  = 4;
	localparam int BYTE_W      = 8;

	localparam logic [5:0] SYNC_RST = 6'h20;

	typedef enum logic [2:0] {
		PWR_STANDBY = 3'b001,
		PWR_ACTIVE  = 3'b010,
		PWR_DEEP    = 3'b100
	} pwr_state_t;

	function automatic logic is_sr_read(input logic [7:0] op);
		return op == OP_RD_STAT1 || op == OP_RD_STAT2 ||
			op == OP_RD_SR3A || op == OP_RD_SR3B;
	endfunction

	function automatic logic is_read(input logic [7:0] op);
		return is_sr_read(op) || op == OP_WAKE;
	endfunction

	function automatic logic is_prog(input logic [7:0] op);
		return op == OP_PAGE_WR || op == OP_QPAGE_WR;
	endfunction

	function automatic logic is_addr_erase(input logic [7:0] op);
		return op == OP_ER_4K || op == OP_ER_32K || op == OP_ER_64K;
	endfunction

	function automatic logic is_erase(input logic [7:0] op);
		return is_addr_erase(op) || op == OP_ER_CHIPA ||
			op == OP_ER_CHIPB;
	endfunction

	function automatic logic is_sr_write(input logic [7:0] op);
		return op == OP_SR_WR1 || op == OP_SR_WR2 || op == OP_SR_WR3;
	endfunction

	function automatic logic is_known(input logic [7:0] op);
		return is_read(op) || is_prog(op) || is_erase(op) ||
			is_sr_write(op) || op == OP_WEL_SET ||
			op == OP_VWEL_SET || op == OP_WEL_CLR || op == OP_WRAP ||
			op == OP_G_LOCK || op == OP_G_UNLOCK ||
			op == OP_SUSPEND || op == OP_RESUME ||
			op == OP_QUAD_ON || op == OP_RST_EN || op == OP_RST ||
			op == OP_SLEEP;
	endfunction

endpackage

// ==== inc/byte_stream_if.sv ====
// valid/ready byte stream between the front end and its payload fifo
`timescale 1ns/10ps
interface byte_stream_if #(parameter int WIDTH = 8);
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] in_data;
	logic             out_valid;
	logic             out_ready;
	logic [WIDTH-1:0] out_data;

	modport fifo (
		input  in_valid,
		output in_ready,
		input  in_data,
		output out_valid,
		input  out_ready,
		output out_data
	);

	modport user (
		output in_valid,
		input  in_ready,
		output in_data,
		input  out_valid,
		output out_ready,
		input  out_data
	);
endinterface

// ==== hdl/byte_fifo.sv ====
// small payload fifo with a registered output stage
`timescale 1ns/10ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// stream
	byte_stream_if.fifo s
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("byte_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             out_valid_q;
	logic [WIDTH-1:0] out_data_q;

	wire push = s.in_valid && s.in_ready;
	wire load = cnt_q != '0 && (!out_valid_q || s.out_ready);

	assign s.in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign s.out_valid = out_valid_q;
	assign s.out_data  = out_data_q;

	always_ff @(posedge mclk_i) begin
		if (push) begin
			mem_q[wr_q] <= s.in_data;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_q        <= '0;
			rd_q        <= '0;
			cnt_q       <= '0;
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
		end else begin
			wr_q  <= push ? wr_q + 1'b1 : wr_q;
			rd_q  <= load ? rd_q + 1'b1 : rd_q;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
			if (load) begin
				out_valid_q <= 1'b1;
				out_data_q  <= mem_q[rd_q];
			end else if (s.out_ready) begin
				out_valid_q <= 1'b0;
			end
		end
	end
endmodule

// ==== hdl/serial_flash_command_front_end.sv ====
// command framing, decode and power state of the serial flash front end
// Notes on behaviour
// - select low means active, accepting commands
// - after deselect stay active until cycle ends
// - sleep-entry command enters deep power-down
// - only wake command leaves deep power-down
// - deep power-down discards all but wake
// - select fall starts frame, first byte opcode
// - single line: rising edge, msb first
// - four-line mode: nibble per edge, msb first
// - select rise ends the instruction
// - reads may end on any bit
// - writes need whole bytes or are dropped
// - busy: only status reads and suspend
// - decode status reads, latch, status writes
// - 50h enables volatile status writes only
// - decode program and erase, three address bytes
// - decode suspend, resume, mode, reset, locks, wrap
// - erase needs prior write latch set
// - page write carries at most one page
// - expose cycle active flag
`timescale 1ns/10ps
module serial_flash_command_front_end #(
	parameter int FIFO_DEPTH = flash_fe_pkg::FIFO_DEPTH,
	parameter int PAGE_BYTES = flash_fe_pkg::PAGE_BYTES
) (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	// serial link from the host
	input  wire logic        cs_n_i,
	input  wire logic        sclk_i,
	input  wire logic [3:0]  io_i,
	// array engine
	input  wire logic        cycle_done_i,
	// payload bytes
	output logic             payload_valid_o,
	input  wire logic        payload_ready_i,
	output logic [7:0]       payload_data_o,
	// committed and dropped frames
	output logic             exec_valid_o,
	output logic [7:0]       exec_cmd_o,
	output logic [23:0]      exec_addr_o,
	output logic             frame_drop_o,
	output logic             soft_reset_o,
	// device state
	output logic             power_active_o,
	output logic             power_standby_o,
	output logic             deep_sleep_o,
	output logic             cycle_active_flag_o,
	output logic             write_latch_o,
	output logic             four_line_command_mode_o,
	output logic             suspended_o
);
	if (PAGE_BYTES < 1 || PAGE_BYTES > 512) begin : g_chk
		$error("page size must lie between 1 and 512 bytes");
	end

	byte_stream_if #(.WIDTH(flash_fe_pkg::BYTE_W)) bs ();

	byte_fifo #(
		.WIDTH (flash_fe_pkg::BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.s      (bs.fifo)
	);

	// link synchroniser: {cs, sclk, io[3:0]}
	logic [5:0] meta_q;
	logic [5:0] sync_q;
	logic       cs_dly_q;
	logic       sclk_dly_q;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta_q     <= flash_fe_pkg::SYNC_RST;
			sync_q     <= flash_fe_pkg::SYNC_RST;
			cs_dly_q   <= 1'b1;
			sclk_dly_q <= 1'b0;
		end else begin
			meta_q     <= {cs_n_i, sclk_i, io_i};
			sync_q     <= meta_q;
			cs_dly_q   <= sync_q[5];
			sclk_dly_q <= sync_q[4];
		end
	end

	wire       cs_n_s            = sync_q[5];
	wire       serial_input_line = sync_q[0];
	wire [3:0] io_s              = sync_q[3:0];
	wire       frame_start       = cs_dly_q && !cs_n_s;
	wire       frame_end         = !cs_dly_q && cs_n_s;
	wire       sclk_rise         = !sclk_dly_q && sync_q[4] && !cs_n_s;

	// frame shifter
	logic [7:0]  shift_q;
	logic [2:0]  bit_cnt_q;
	logic [9:0]  byte_cnt_q;
	logic [7:0]  op_q;
	logic [23:0] addr_q;
	logic        overrun_q;
	logic        quad_q;
	logic        busy_q;
	logic        wel_q;
	logic        vwel_q;
	logic        susp_q;
	logic        rst_en_q;
	flash_fe_pkg::pwr_state_t pwr_q;
	flash_fe_pkg::pwr_state_t pwr_d;

	// quad page write sends its data nibble-wide even from one-line mode
	wire lanes4 = quad_q || (op_q == flash_fe_pkg::OP_QPAGE_WR &&
		byte_cnt_q > 10'(flash_fe_pkg::ADDR_BYTES));
	wire [7:0] shift_d = lanes4 ? {shift_q[3:0], io_s} :
		{shift_q[6:0], serial_input_line};
	wire [2:0] bit_nx    = bit_cnt_q + (lanes4 ? 3'h4 : 3'h1);
	wire       byte_done = sclk_rise && bit_nx == 3'h0;
	wire       has_op    = byte_cnt_q != 10'h000;
	wire       in_addr   = has_op &&
		byte_cnt_q <= 10'(flash_fe_pkg::ADDR_BYTES);

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shift_q    <= 8'h00;
			bit_cnt_q  <= 3'h0;
			byte_cnt_q <= 10'h000;
			op_q       <= 8'h00;
			addr_q     <= 24'h000000;
		end else if (frame_start) begin
			bit_cnt_q  <= 3'h0;
			byte_cnt_q <= 10'h000;
		end else if (sclk_rise) begin
			shift_q   <= shift_d;
			bit_cnt_q <= bit_nx;
			if (byte_done && byte_cnt_q != 10'h3FF) begin
				byte_cnt_q <= byte_cnt_q + 10'h001;
			end
			if (byte_done && !has_op) begin
				op_q <= shift_d;
			end
			if (byte_done && in_addr) begin
				addr_q <= {addr_q[15:0], shift_d};
			end
		end
	end

	// payload bytes that belong to the current opcode
	wire [9:0] pay_idx = byte_cnt_q - 10'(flash_fe_pkg::ADDR_BYTES);
	wire pay_prog = flash_fe_pkg::is_prog(op_q) && !in_addr &&
		pay_idx <= 10'(PAGE_BYTES);
	wire pay_sr1 = op_q == flash_fe_pkg::OP_SR_WR1 &&
		byte_cnt_q <= 10'(flash_fe_pkg::SR_WR_MAX);
	wire pay_sr23 = (op_q == flash_fe_pkg::OP_SR_WR2 ||
		op_q == flash_fe_pkg::OP_SR_WR3) && byte_cnt_q == 10'h001;
	wire pay_wrap = op_q == flash_fe_pkg::OP_WRAP &&
		byte_cnt_q == 10'(flash_fe_pkg::WRAP_BYTE);
	wire push = byte_done && has_op && !busy_q && pwr_q !=
		flash_fe_pkg::PWR_DEEP && (pay_prog || pay_sr1 || pay_sr23 ||
		pay_wrap);

	assign bs.in_valid  = push;
	assign bs.in_data   = shift_d;
	assign bs.out_ready = payload_ready_i;

	// a byte that found the fifo full spoils the whole frame
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			overrun_q <= 1'b0;
		end else if (push && !bs.in_ready) begin
			overrun_q <= 1'b1;
		end else if (frame_start) begin
			overrun_q <= 1'b0;
		end
	end

	// end-of-frame decode
	wire aligned   = bit_cnt_q == 3'h0;
	wire known     = flash_fe_pkg::is_known(op_q);
	wire rd_type   = flash_fe_pkg::is_read(op_q);
	wire busy_ok   = !busy_q || flash_fe_pkg::is_sr_read(op_q) ||
		op_q == flash_fe_pkg::OP_SUSPEND;
	wire sleep_ok  = pwr_q != flash_fe_pkg::PWR_DEEP ||
		op_q == flash_fe_pkg::OP_WAKE;
	wire need_wel  = flash_fe_pkg::is_prog(op_q) ||
		flash_fe_pkg::is_erase(op_q);
	wire sr_wr     = flash_fe_pkg::is_sr_write(op_q);
	wire wel_ok    = (!need_wel || wel_q) &&
		(!sr_wr || wel_q || vwel_q);
	wire addr_ok   = !(flash_fe_pkg::is_prog(op_q) ||
		flash_fe_pkg::is_addr_erase(op_q)) ||
		byte_cnt_q > 10'(flash_fe_pkg::ADDR_BYTES);
	wire accept    = frame_end && has_op && known && busy_ok &&
		(rd_type || aligned) && sleep_ok && wel_ok && addr_ok &&
		!overrun_q;
	wire drop      = frame_end && has_op && !accept;
	wire reset_hit = accept && op_q == flash_fe_pkg::OP_RST &&
		rst_en_q;
	wire starts    = accept && (need_wel || (sr_wr && wel_q));
	wire acc_susp  = accept && op_q == flash_fe_pkg::OP_SUSPEND &&
		busy_q;
	wire acc_res   = accept && op_q == flash_fe_pkg::OP_RESUME &&
		susp_q;
	wire acc_sleep = accept && op_q == flash_fe_pkg::OP_SLEEP;
	wire acc_wake  = accept && op_q == flash_fe_pkg::OP_WAKE;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			busy_q <= 1'b0;
			susp_q <= 1'b0;
		end else begin
			// a new start beats a coincident completion
			busy_q <= starts || acc_res ||
				(busy_q && !cycle_done_i && !acc_susp);
			susp_q <= acc_susp || (susp_q && !acc_res && !reset_hit);
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wel_q    <= 1'b0;
			vwel_q   <= 1'b0;
			quad_q   <= 1'b0;
			rst_en_q <= 1'b0;
		end else begin
			if (accept && op_q == flash_fe_pkg::OP_WEL_SET) begin
				wel_q <= 1'b1;
			end else if (starts || reset_hit ||
				(accept && op_q == flash_fe_pkg::OP_WEL_CLR)) begin
				wel_q <= 1'b0;
			end
			if (accept && op_q == flash_fe_pkg::OP_VWEL_SET) begin
				vwel_q <= 1'b1;
			end else if (reset_hit || (accept && sr_wr)) begin
				vwel_q <= 1'b0;
			end
			if (reset_hit) begin
				quad_q <= 1'b0;
			end else if (accept && op_q == flash_fe_pkg::OP_QUAD_ON) begin
				quad_q <= 1'b1;
			end
			// any other finished frame cancels a pending enable
			if (frame_end && has_op) begin
				rst_en_q <= accept &&
					op_q == flash_fe_pkg::OP_RST_EN;
			end
		end
	end

	// power state
	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			flash_fe_pkg::PWR_STANDBY: begin
				if (!cs_n_s || busy_q) begin
					pwr_d = flash_fe_pkg::PWR_ACTIVE;
				end
			end
			flash_fe_pkg::PWR_ACTIVE: begin
				if (acc_sleep) begin
					pwr_d = flash_fe_pkg::PWR_DEEP;
				// a cycle starting on this edge already counts as busy
				end else if (cs_n_s && !busy_q && !starts && !acc_res) begin
					pwr_d = flash_fe_pkg::PWR_STANDBY;
				end
			end
			flash_fe_pkg::PWR_DEEP: begin
				if (acc_wake) begin
					pwr_d = flash_fe_pkg::PWR_ACTIVE;
				end
			end
			default: pwr_d = flash_fe_pkg::PWR_STANDBY;
		endcase
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pwr_q        <= flash_fe_pkg::PWR_STANDBY;
			exec_valid_o <= 1'b0;
			exec_cmd_o   <= 8'h00;
			exec_addr_o  <= 24'h000000;
			frame_drop_o <= 1'b0;
			soft_reset_o <= 1'b0;
		end else begin
			pwr_q        <= pwr_d;
			exec_valid_o <= accept;
			frame_drop_o <= drop;
			soft_reset_o <= reset_hit;
			if (accept) begin
				exec_cmd_o  <= op_q;
				exec_addr_o <= addr_q;
			end
		end
	end

	assign payload_valid_o          = bs.out_valid;
	assign payload_data_o           = bs.out_data;
	assign power_standby_o          = pwr_q[0];
	assign power_active_o           = pwr_q[1];
	assign deep_sleep_o             = pwr_q[2];
	assign cycle_active_flag_o      = busy_q;
	assign write_latch_o            = wel_q;
	assign four_line_command_mode_o = quad_q;
	assign suspended_o              = susp_q;

	a_deep_discard: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		frame_end && deep_sleep_o && op_q != flash_fe_pkg::OP_WAKE
		|=> !exec_valid_o && deep_sleep_o)
		else $error("command executed in deep power-down");

	a_busy_ignore: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		frame_end && busy_q && !flash_fe_pkg::is_sr_read(op_q) &&
		op_q != flash_fe_pkg::OP_SUSPEND |=> !exec_valid_o)
		else $error("command accepted during busy cycle");

	a_write_align: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		frame_end && bit_cnt_q != 3'h0 && !flash_fe_pkg::is_read(op_q)
		|=> !exec_valid_o ##1 !exec_valid_o)
		else $error("unaligned write frame executed");

	a_erase_latch: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		exec_valid_o && flash_fe_pkg::is_erase(exec_cmd_o)
		|-> $past(wel_q, 1) && cycle_active_flag_o && !write_latch_o)
		else $error("erase started without write latch");

	a_reset_pair: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		soft_reset_o |-> $past(rst_en_q, 1) && exec_cmd_o ==
		flash_fe_pkg::OP_RST && !four_line_command_mode_o)
		else $error("reset without directly preceding enable");

	a_select_active: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		!cs_n_s && !deep_sleep_o |=> power_active_o)
		else $error("selected device not active");

	a_stay_active: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		power_standby_o |-> !cycle_active_flag_o)
		else $error("standby entered while cycle in progress");

	a_sleep_entry: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		exec_valid_o && exec_cmd_o == flash_fe_pkg::OP_SLEEP
		|-> deep_sleep_o [*3])
		else $error("sleep command did not enter deep power-down");

	a_unknown_nop: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		exec_valid_o |-> flash_fe_pkg::is_known(exec_cmd_o))
		else $error("unknown opcode executed");

	a_unknown_drop: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		frame_end && has_op && !known |=> frame_drop_o && !exec_valid_o)
		else $error("unknown opcode not dropped");
endmodule

// ==== verification/flash_host_model.sv ====
// host side of the serial link: select, clock and data lines
`timescale 1ns/10ps
module flash_host_model (
	// clock of the bench
	input  wire logic       mclk_i,
	// serial link to the device
	output logic            cs_n_o,
	output logic            sclk_o,
	output logic [3:0]      io_o
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		io_o = 4'hA;
	end

	// four system clocks per half period gives the 320 ns link clock
	task automatic half_period();
		repeat (4) @(posedge mclk_i);
		#1;
	endtask

	// d is left aligned; nbits may stop short of a byte on purpose
	task automatic xfer(input logic [95:0] d, input int nbits,
			input logic quad);
		int i;
		half_period();
		cs_n_o = 1'b0;
		for (i = 0; i < nbits; i = i + (quad ? 4 : 1)) begin
			half_period();
			sclk_o = 1'b0;
			if (quad)
				io_o = d[95-i -: 4];
			else
				io_o = {{3{~d[95-i]}}, d[95-i]};
			half_period();
			sclk_o = 1'b1;
		end
		half_period();
		sclk_o = 1'b0;
		half_period();
		cs_n_o = 1'b1;
		// released lines have no pull, so show the inverse
		io_o = ~io_o;
	endtask
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench of the serial flash command front end
`timescale 1ns/10ps
module tb_top;
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        cycle_done_i = 1'b0;
	logic        payload_ready_i = 1'b1;
	logic        cs_n, sclk;
	logic [3:0]  io;
	logic        payload_valid_o, exec_valid_o, frame_drop_o;
	logic        soft_reset_o, power_active_o, power_standby_o;
	logic        deep_sleep_o, cycle_active_flag_o, write_latch_o;
	logic        four_line_command_mode_o, suspended_o;
	logic [7:0]  payload_data_o, exec_cmd_o;
	logic [23:0] exec_addr_o;
	logic        seen_rst;
	int          mismatches = 0;
	int          comparisons = 0;

	always #20 mclk_i = ~mclk_i;

	flash_host_model flash_host_model_inst (.mclk_i(mclk_i),
		.cs_n_o(cs_n), .sclk_o(sclk), .io_o(io));

	serial_flash_command_front_end serial_flash_command_front_end_inst (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sclk_i(sclk),
		.io_i(io), .cycle_done_i(cycle_done_i),
		.payload_valid_o(payload_valid_o),
		.payload_ready_i(payload_ready_i),
		.payload_data_o(payload_data_o), .exec_valid_o(exec_valid_o),
		.exec_cmd_o(exec_cmd_o), .exec_addr_o(exec_addr_o),
		.frame_drop_o(frame_drop_o), .soft_reset_o(soft_reset_o),
		.power_active_o(power_active_o),
		.power_standby_o(power_standby_o), .deep_sleep_o(deep_sleep_o),
		.cycle_active_flag_o(cycle_active_flag_o),
		.write_latch_o(write_latch_o),
		.four_line_command_mode_o(four_line_command_mode_o),
		.suspended_o(suspended_o));

	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [23:0] exp,
			input logic [23:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// want: 1 accepted, 2 dropped; the outcome pulses last one cycle
	task automatic frame(input logic [95:0] d, input int nbits,
			input logic quad, input logic [1:0] want);
		logic [1:0] seen;
		seen = 2'b00;
		seen_rst = 1'b0;
		flash_host_model_inst.xfer(d, nbits, quad);
		repeat (12) begin
			@(posedge mclk_i);
			#1;
			seen = seen | {frame_drop_o === 1'b1, exec_valid_o === 1'b1};
			seen_rst = seen_rst | (soft_reset_o === 1'b1);
		end
		chk("frame outcome", {22'h0, want}, {22'h0, seen});
		if (seen == 2'b00)
			complete_run();
	endtask

	task automatic finish_cycle();
		@(posedge mclk_i);
		#1 cycle_done_i = 1'b1;
		@(posedge mclk_i);
		#1 cycle_done_i = 1'b0;
		repeat (2) @(posedge mclk_i);
		#1;
		chk("cycle flag", 24'h0, {23'h0, cycle_active_flag_o});
		chk("standby", 24'h1, {23'h0, power_standby_o});
	endtask

	task automatic t_decode();
		logic [7:0] ops [10] = '{8'h05, 8'h35, 8'h15, 8'h33, 8'h06,
			8'h04, 8'h50, 8'h7E, 8'h98, 8'h77};
		int i;
		for (i = 0; i < 10; i++) begin
			frame({ops[i], 88'h0}, ops[i] == 8'h77 ? 40 : 8, 1'b0,
				2'd1);
			chk("exec cmd", {16'h0, ops[i]}, {16'h0, exec_cmd_o});
			if (ops[i] == 8'h06 || ops[i] == 8'h04)
				chk("latch", {23'h0, ops[i] == 8'h06},
					{23'h0, write_latch_o});
		end
		frame({8'hA5, 88'h0}, 8, 1'b0, 2'd2);
	endtask

	task automatic t_program_erase();
		logic [7:0] ops [8] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60,
			8'h01, 8'h31, 8'h11};
		int nb [8] = '{32, 32, 32, 8, 8, 32, 16, 16};
		int i;
		frame({8'h20, 24'h000100, 64'h0}, 32, 1'b0, 2'd2);
		for (i = 0; i < 8; i++) begin
			frame({8'h06, 88'h0}, 8, 1'b0, 2'd1);
			fork
				frame({ops[i], 24'h123456, 64'h0}, nb[i], 1'b0, 2'd1);
				begin
					repeat (30) @(posedge mclk_i);
					#1 chk("active", 24'h1, {23'h0, power_active_o});
				end
			join
			chk("exec cmd", {16'h0, ops[i]}, {16'h0, exec_cmd_o});
			if (nb[i] == 32 && i < 3)
				chk("exec addr", 24'h123456, exec_addr_o);
			chk("cycle flag", 24'h1, {23'h0, cycle_active_flag_o});
			if (i == 0) begin
				frame({8'h75, 88'h0}, 8, 1'b0, 2'd1);
				chk("suspended", 24'h1, {23'h0, suspended_o});
				frame({8'h7A, 88'h0}, 8, 1'b0, 2'd1);
				chk("resumed", 24'h1, {23'h0, cycle_active_flag_o});
				chk("resume active", 24'h1, {23'h0, power_active_o});
			end
			if (i == 2) begin
				frame({8'h06, 88'h0}, 8, 1'b0, 2'd2);
				frame({8'h05, 88'h0}, 8, 1'b0, 2'd1);
				chk("busy active", 24'h1, {23'h0, power_active_o});
			end
			finish_cycle();
		end
	endtask

	task automatic t_boundary();
		frame({8'h06, 88'h0}, 8, 1'b0, 2'd1);
		frame({8'h20, 24'h000100, 64'h0}, 35, 1'b0, 2'd2);
		frame({8'h20, 24'h000100, 64'h0}, 16, 1'b0, 2'd2);
		frame({8'h04, 88'h0}, 8, 1'b0, 2'd1);
		frame({8'h05, 88'h0}, 13, 1'b0, 2'd1);
	endtask

	task automatic t_sleep();
		frame({8'hB9, 88'h0}, 8, 1'b0, 2'd1);
		chk("deep sleep", 24'h1, {23'h0, deep_sleep_o});
		frame({8'h06, 88'h0}, 8, 1'b0, 2'd2);
		frame({8'h20, 24'h0, 64'h0}, 32, 1'b0, 2'd2);
		frame({8'hAB, 88'h0}, 8, 1'b0, 2'd1);
		chk("deep sleep", 24'h0, {23'h0, deep_sleep_o});
	endtask

	task automatic t_reset_mode();
		frame({8'h66, 88'h0}, 8, 1'b0, 2'd1);
		frame({8'h05, 88'h0}, 8, 1'b0, 2'd1);
		frame({8'h99, 88'h0}, 8, 1'b0, 2'd1);
		chk("soft reset", 24'h0, {23'h0, seen_rst});
		frame({8'h38, 88'h0}, 8, 1'b0, 2'd1);
		chk("four line", 24'h1, {23'h0, four_line_command_mode_o});
		frame({8'h06, 88'h0}, 8, 1'b1, 2'd1);
		chk("latch", 24'h1, {23'h0, write_latch_o});
		frame({8'h66, 88'h0}, 8, 1'b1, 2'd1);
		frame({8'h99, 88'h0}, 8, 1'b1, 2'd1);
		chk("soft reset", 24'h1, {23'h0, seen_rst});
		chk("four line", 24'h0, {23'h0, four_line_command_mode_o});
	endtask

	// consumer stalls until the buffer refuses, then drains it
	task automatic t_payload();
		logic [47:0] pay = 48'h112233445566;
		int n;
		int k = 0;
		payload_ready_i = 1'b0;
		frame({8'h06, 88'h0}, 8, 1'b0, 2'd1);
		frame({8'h02, 24'h000100, pay, 16'h0}, 80, 1'b0, 2'd2);
		payload_ready_i = 1'b1;
		for (n = 0; n < 20; n++) begin
			if (payload_valid_o === 1'b1) begin
				chk("payload", {16'h0, pay[47-8*k -: 8]},
					{16'h0, payload_data_o});
				k++;
			end
			@(posedge mclk_i);
			#1;
		end
		chk("payload count", 24'd5, k[23:0]);
		frame({8'h06, 88'h0}, 8, 1'b0, 2'd1);
		frame({8'h02, 24'hABCDEF, 16'hC3A5, 48'h0}, 48, 1'b0, 2'd1);
		chk("exec addr", 24'hABCDEF, exec_addr_o);
		finish_cycle();
	endtask

	initial begin
		#4000000;
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (12) @(posedge mclk_i);
		#1 nrst_i = 1'b1;
		chk("reset state", 24'h40, {17'h0, power_standby_o, power_active_o,
			deep_sleep_o, cycle_active_flag_o, write_latch_o,
			four_line_command_mode_o, suspended_o});
		t_decode();
		t_program_erase();
		t_boundary();
		t_sleep();
		t_reset_mode();
		t_payload();
		complete_run();
	end
endmodule
